// [rtl/chg_status_pkg.sv]
// Constants for the charger status and disable pin logic
package chg_status_pkg;

  // Clock rate and fault pulse length
  localparam int unsigned CLK_MHZ        = 100;  // Core clock, MHz
  localparam int unsigned FAULT_PULSE_US = 128;  // Fault pulse, us
  // Pulse cycles, exact product of pulse length and clock rate
  localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  localparam int unsigned CNT_W = $clog2(FAULT_PULSE_CYC + 1);

  // Charger operating state
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,  // Not charging, not disabled
    ST_CHARGE = 2'b01,  // Charge cycle running
    ST_DONE   = 2'b10,  // Charging complete
    ST_HIZ    = 2'b11   // High-impedance mode
  } chg_state_t;

endpackage : chg_status_pkg

// [rtl/chg_status.sv]
// Charger state, hardware disable and open-drain status line driver
//
// Function
// - Disable high forces high-impedance, no charging
// - Status line pulled low while charging
// - Line released when done or disabled
// - Each fault starts or restarts a 128 us pulse
// - Line driven only when enable bit set
// - Second status line follows identical scheme
// - Safety timer expiry halts, pulses both lines
`timescale 1ns/100ps

module chg_status
  import chg_status_pkg::*;
(
  input  wire logic clock,             // 100 MHz core clock
  input  wire logic srst,              // Synchronous reset, active high
  input  wire logic hw_disable_input,  // Asynchronous disable pin
  input  wire logic stat_en,           // Status output enable bit
  input  wire logic charge_start,      // Pulse: start a charge cycle
  input  wire logic charge_term,       // Pulse: termination reached
  input  wire logic fault_evt,         // Pulse: generic fault
  input  wire logic safety_expire,     // Pulse: safety timer expired
  output logic      hiz_mode,          // High-impedance mode active
  output logic      charge_on,         // Charge current allowed
  output logic      int_o,             // Interrupt line level (always 0)
  output logic      int_oe,            // Interrupt line pull-down enable
  output logic      stat_o,            // Status line level (always 0)
  output logic      stat_oe            // Status line pull-down enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic dis_s1_ff;     // First stage, read only by second stage
  logic dis_s2_ff;     // Synchronised disable level
  logic nxt_dis_s1;
  logic nxt_dis_s2;

  // Next values of the synchroniser
  always_comb begin
    nxt_dis_s1 = hw_disable_input;
    nxt_dis_s2 = dis_s1_ff;
    if (srst) begin
      nxt_dis_s1 = 1'b0;
      nxt_dis_s2 = 1'b0;
    end
  end

  // Register the synchroniser; the host must not float the pin
  always_ff @(posedge clock) begin
    dis_s1_ff <= nxt_dis_s1;
    dis_s2_ff <= nxt_dis_s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge state machine

  chg_state_t state_ff;   // Operating state
  chg_state_t nxt_state;

  // Disable wins over every other event except reset
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (charge_start) begin
          nxt_state = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        // Safety expiry halts the cycle
        if (safety_expire) begin
          nxt_state = ST_IDLE;
        end else if (charge_term) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (charge_start) begin
          nxt_state = ST_CHARGE;
        end
      end
      ST_HIZ: begin
        // Leave only when the pin is low again
        if (!dis_s2_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (dis_s2_ff) begin
      nxt_state = ST_HIZ;
    end
    if (srst) begin
      nxt_state = ST_IDLE;
    end
  end

  // Register the state
  always_ff @(posedge clock) begin
    state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault pulse timer

  logic [CNT_W-1:0] pulse_cnt_ff;  // Remaining pulse cycles
  logic [CNT_W-1:0] nxt_pulse_cnt;
  logic             fault_any;     // Any fault event this cycle

  // A new fault restarts the pulse; overlap merges into one low period
  always_comb begin
    fault_any     = fault_evt | (safety_expire && state_ff == ST_CHARGE);
    nxt_pulse_cnt = pulse_cnt_ff;
    if (fault_any) begin
      nxt_pulse_cnt = CNT_W'(FAULT_PULSE_CYC);
    end else if (pulse_cnt_ff != '0) begin
      nxt_pulse_cnt = pulse_cnt_ff - CNT_W'(1);
    end
    if (srst) begin
      nxt_pulse_cnt = '0;
    end
  end

  // Register the counter
  always_ff @(posedge clock) begin
    pulse_cnt_ff <= nxt_pulse_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers

  logic nxt_hiz;
  logic nxt_charge_on;
  logic nxt_pull;       // Shared pull-down for both lines
  logic pulse_next;     // Pulse active in the next cycle

  // Both lines use one pull-down term, so they never diverge
  always_comb begin
    pulse_next    = (nxt_pulse_cnt != '0);
    nxt_hiz       = (nxt_state == ST_HIZ);
    nxt_charge_on = (nxt_state == ST_CHARGE);
    // Low while charging, pulse on fault, released otherwise
    nxt_pull      = (nxt_charge_on | pulse_next) & stat_en;
    if (srst) begin
      nxt_hiz       = 1'b0;
      nxt_charge_on = 1'b0;
      nxt_pull      = 1'b0;
    end
  end

  // All outputs straight from flip-flops
  always_ff @(posedge clock) begin
    hiz_mode  <= nxt_hiz;
    charge_on <= nxt_charge_on;
    int_oe    <= nxt_pull;
    stat_oe   <= nxt_pull;
    int_o     <= 1'b0;
    stat_o    <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence fault_seen_s;
    (fault_evt && !srst);
  endsequence

  sequence pulse_hold_s;
    (pulse_cnt_ff != '0) [*8];
  endsequence

  hiz_entry_a : assert property (
    dis_s2_ff |=> hiz_mode && !charge_on)
    else $error("Disable did not force high-impedance");

  hiz_exit_a : assert property (
    (state_ff == ST_HIZ && !dis_s2_ff) |=> !hiz_mode)
    else $error("High-impedance mode not left");

  charge_go_a : assert property (
    (charge_start && state_ff != ST_CHARGE && state_ff != ST_HIZ
      && !dis_s2_ff) |=> charge_on)
    else $error("Charge start not taken");

  charge_pull_a : assert property (
    (charge_on && $past(stat_en)) |-> int_oe)
    else $error("Line not pulled while charging");

  release_a : assert property (
    (hiz_mode && pulse_cnt_ff == '0 && $past(pulse_cnt_ff) == '0)
      |-> !int_oe)
    else $error("Line not released when disabled");

  pulse_len_a : assert property (
    fault_seen_s |=> (pulse_cnt_ff == CNT_W'(FAULT_PULSE_CYC)) ##1
      pulse_hold_s)
    else $error("Fault pulse length wrong");

  gate_off_a : assert property (
    !$past(stat_en) |-> !int_oe && !stat_oe)
    else $error("Line driven with enable clear");

  lines_match_a : assert property (
    int_oe == stat_oe && !int_o && !stat_o)
    else $error("Status lines diverge");

  safety_halt_a : assert property (
    (safety_expire && state_ff == ST_CHARGE && !dis_s2_ff)
      |=> !charge_on && pulse_cnt_ff == CNT_W'(FAULT_PULSE_CYC))
    else $error("Safety expiry did not halt and pulse");

  pulse_end_a : assert property (
    (pulse_cnt_ff == CNT_W'(1) && !fault_any) |=> pulse_cnt_ff == '0)
    else $error("Pulse did not end on time");

endmodule : chg_status

// [testbench/host_model.sv]
// Host side of the status and disable pins, with line pull-ups
`timescale 1ns/100ps

module host_model (
  input  wire logic int_o,      // Charger interrupt line level
  input  wire logic int_oe,     // Charger pulls interrupt line
  input  wire logic stat_o,     // Charger status line level
  input  wire logic stat_oe,    // Charger pulls status line
  input  wire logic dis_req,    // Host wish to disable charger
  output logic      int_line,   // Resolved interrupt line
  output logic      stat_line,  // Resolved status line
  output logic      dis_pin     // Disable pin, always defined
);
  // Released lines rise to the pull-up; resolved combinationally
  assign int_line  = int_oe ? int_o : 1'b1;
  assign stat_line = stat_oe ? stat_o : 1'b1;
  // Unknown request still gives a defined low
  assign dis_pin   = (dis_req === 1'b1);
endmodule : host_model

// [testbench/chg_status_test.sv]
// Self-checking bench for the charger status and disable pins
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module chg_status_test;
  import chg_status_pkg::*;
  logic       clock, srst, dis_req, stat_en, cs, ct, fe, se;
  logic       hiz_mode, charge_on, int_o, int_oe, stat_o, stat_oe;
  logic       int_line, stat_line, dis_pin;
  logic [3:0] expq[$];  // Notes: {hiz, charging, int line, stat line}
  logic [3:0] exp_n, got_n;  // Oldest note and observed outputs
  logic [2:0] dis_hist;      // Disable requests of the last three edges
  logic       en_prev, rnd;  // Enable applied last edge, random draw
  int         n_errors, total_checks, cycles, seed;

  chg_status u_chg_status (.clock(clock), .srst(srst),
    .hw_disable_input(dis_pin), .stat_en(stat_en), .charge_start(cs),
    .charge_term(ct), .fault_evt(fe), .safety_expire(se),
    .hiz_mode(hiz_mode), .charge_on(charge_on), .int_o(int_o),
    .int_oe(int_oe), .stat_o(stat_o), .stat_oe(stat_oe));
  host_model u_host_model (.int_o(int_o), .int_oe(int_oe),
    .stat_o(stat_o), .stat_oe(stat_oe), .dis_req(dis_req),
    .int_line(int_line), .stat_line(stat_line), .dis_pin(dis_pin));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One-cycle strobe; the two extra ticks hide the one-edge answer latency
  task strobe(input int which);
    case (which)
      0: cs <= 1'b1;
      1: ct <= 1'b1;
      2: fe <= 1'b1;
      default: se <= 1'b1;
    endcase
    tick(1);
    {cs, ct, fe, se} <= 4'h0;
    tick(2);
  endtask : strobe

  task final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Watcher: takes the oldest note once outputs have settled
  always @(negedge clock) begin
    if (expq.size() > 0) begin
      exp_n = expq.pop_front();
      got_n = {hiz_mode, charge_on, int_line, stat_line};
      `CHK(got_n, exp_n)
    end
  end

  // Hang guard, well above the two long pulses
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    {srst, dis_req, stat_en, cs, ct, fe, se} <= 7'h50;
    seed = 40;
    tick(4);
    srst <= 1'b0;
    tick(2);
    expq.push_back(4'h3);
    strobe(0);
    expq.push_back(4'h4);
    strobe(1);
    expq.push_back(4'h3);
    // Fault pulse length, probed just inside and outside its span
    strobe(2);
    expq.push_back(4'h0);
    tick(FAULT_PULSE_CYC - 10);
    expq.push_back(4'h0);
    tick(15);
    expq.push_back(4'h3);
    strobe(0);
    strobe(3);
    expq.push_back(4'h0);
    tick(FAULT_PULSE_CYC + 5);
    expq.push_back(4'h3);
    // Enable bit low: charging but both lines left alone
    stat_en <= 1'b0;
    tick(2);
    strobe(0);
    expq.push_back(4'h7);
    stat_en <= 1'b1;
    tick(3);
    expq.push_back(4'h4);
    tick(1);
    // Random enable while charging; gating lands one edge later
    en_prev = 1'b1;
    repeat (24) begin
      expq.push_back({2'b01, ~en_prev, ~en_prev});
      rnd = 1'($random(seed));
      stat_en <= rnd;
      en_prev = rnd;
      tick(1);
    end
    stat_en <= 1'b1;
    tick(2);
    dis_req <= 1'b1;
    tick(5);
    expq.push_back(4'hB);
    // Random strobes while disabled must change nothing
    repeat (20) begin
      cs <= 1'($random(seed));
      ct <= 1'($random(seed));
      se <= 1'($random(seed));
      tick(1);
    end
    {cs, ct, se} <= 3'h0;
    tick(2);
    expq.push_back(4'hB);
    dis_req <= 1'b0;
    tick(6);
    expq.push_back(4'h3);
    tick(2);
    // Random disable pin: mode follows three edges later, both ways
    dis_hist = 3'h0;
    repeat (24) begin
      expq.push_back({dis_hist[2], 3'h3});
      rnd = 1'($random(seed));
      dis_req <= rnd;
      dis_hist = {dis_hist[1:0], rnd};
      tick(1);
    end
    dis_req <= 1'b0;
    tick(6);
    expq.push_back(4'h3);
    tick(2);
    final_report();
  end
endmodule : chg_status_test
